// ===== core/dpalu.sv
// Purpose: Data-processing ALU with flag generation and PC/status handling.
// Assumes: Decoder gives one operation per valid cycle; shifter output arrives
//          on the same cycle with its last carry out and a shift-occurred flag.
// Notes: Results and status word update on the clock edge after op_valid.
`timescale 1ns/100ps

// Overview of operation
// - Add-with-carry writes first plus second plus stored carry.
// - Subtract writes first minus second.
// - Subtract-with-carry: first minus second, minus one more if carry clear.
// - Reverse subtract writes second minus first.
// - Reverse subtract-with-carry: second minus first, minus one if carry clear.
// - Conjunction writes bitwise AND of both operands.
// - Bit clear writes first AND inverted second.
// - Disjunction writes bitwise OR of both operands.
// - Exclusive disjunction writes bitwise XOR of both operands.
// - Additions set carry when the unsigned 32-bit sum overflows.
// - Subtractions set carry exactly when no unsigned borrow occurred.
// - Arithmetic overflow is carry into bit 31 differing from carry out.
// - Compares subtract or add, update all four flags, write no destination.
// - Tests XOR or AND, set N Z, keep V, take carry from shifter or keep it.
// - Status-write compare in user mode loads four flags from result top.
// - Status-write compare elsewhere loads top six bits and mode bits.
// - PC destination without flag update writes only the 24 counter bits.
// - User mode PC destination with flag update writes counter and flags.
// - Privileged PC destination with flag update writes all 32 bits.
// - PC as first operand reaches the ALU with status bits zero.
// - PC as second operand reaches shifter with status bits intact.
// - PC as shift amount reaches shifter with status bits zero.
// - Computed flags of non-compare, non-test ops are stored only when the flag-update bit is set.
// - Logical ops keep V and take carry from shifter or keep it.
// - Move places second operand; move-inverted places its inverse.
module dpalu (
  input wire logic clock,
  input wire logic reset,
  input wire logic op_valid,
  input wire dpalu_pkg::dpalu_op_t op_code,
  input wire logic set_flags,
  input wire logic status_write,
  input wire logic dest_is_pc,
  input wire logic [31:0] first_source_reg,
  input wire logic first_is_pc,
  input wire logic [31:0] second_operand,
  input wire logic shifter_carry,
  input wire logic shift_occurred,
  input wire logic [31:0] shifter_source,
  input wire logic shifter_source_is_pc,
  input wire logic [31:0] amount_source,
  input wire logic amount_is_pc,
  output logic [31:0] result_reg,
  output logic dest_write_reg,
  output logic [31:0] pc_status_reg,
  output logic [31:0] shifter_operand_reg,
  output logic [31:0] shift_amount_reg
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] result;
    logic dest_write;
    logic [31:0] shifter_operand;
    logic [31:0] shift_amount;
  } dpalu_state_t;

  dpalu_state_t state_reg;
  dpalu_state_t state_next;

  logic [31:0] first_op;
  logic [31:0] shifter_word;
  logic [31:0] amount_word;
  logic [31:0] alu_value;
  logic carry_in_flag;
  logic is_arith;
  logic is_cmp_test;
  logic user_mode;
  logic flag_n;
  logic flag_z;
  logic flag_c;
  logic flag_v;
  logic [31:0] write_mask;

  dpalu_add_if add_bus ();

  // ----------------------------------------------------------------
  // Operand presentation
  // ----------------------------------------------------------------
  // First operand: PC word with status cleared so flags never add in
  dpalu_status_gate #(.CLEAR_STATUS(1'b1)) first_gate (
    .word_in(first_source_reg),
    .pc_word(state_reg.status),
    .from_pc(first_is_pc),
    .word_out(first_op)
  );

  // Shifter operand: whole word passed, status bits included
  dpalu_status_gate #(.CLEAR_STATUS(1'b0)) shifter_gate (
    .word_in(shifter_source),
    .pc_word(state_reg.status),
    .from_pc(shifter_source_is_pc),
    .word_out(shifter_word)
  );

  // Shift amount: status cleared, else mode bits would skew the count
  dpalu_status_gate #(.CLEAR_STATUS(1'b1)) amount_gate (
    .word_in(amount_source),
    .pc_word(state_reg.status),
    .from_pc(amount_is_pc),
    .word_out(amount_word)
  );

  dpalu_adder adder (
    .bus(add_bus)
  );

  // ----------------------------------------------------------------
  // Adder steering
  // ----------------------------------------------------------------
  // Carry in always taken from the stored flag, not a forwarded one
  assign carry_in_flag = state_reg.status[dpalu_pkg::FLAG_C_POS];
  assign user_mode = state_reg.status[dpalu_pkg::MODE_HI_POS:dpalu_pkg::MODE_LO_POS]
                     == dpalu_pkg::USER_MODE;

  // Subtraction is a plus inverted b plus one, so carry means no borrow
  always_comb
  begin
    add_bus.a = first_op;
    add_bus.b = second_operand;
    add_bus.cin = 1'b0;
    is_arith = 1'b1;
    case (op_code)
      dpalu_pkg::add_op, dpalu_pkg::compare_negated_op: add_bus.cin = 1'b0;
      dpalu_pkg::add_carry_op: add_bus.cin = carry_in_flag;
      dpalu_pkg::subtract_op, dpalu_pkg::compare_op:
      begin
        add_bus.b = ~second_operand;
        add_bus.cin = 1'b1;
      end
      dpalu_pkg::subtract_with_carry_op:
      begin
        add_bus.b = ~second_operand;
        add_bus.cin = carry_in_flag;
      end
      dpalu_pkg::reverse_subtract_op:
      begin
        add_bus.a = second_operand;
        add_bus.b = ~first_op;
        add_bus.cin = 1'b1;
      end
      dpalu_pkg::reverse_subtract_carry_op:
      begin
        add_bus.a = second_operand;
        add_bus.b = ~first_op;
        add_bus.cin = carry_in_flag;
      end
      default: is_arith = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Result and flags
  // ----------------------------------------------------------------
  // Logical results; arithmetic falls through to the adder sum
  always_comb
  begin
    alu_value = add_bus.sum;
    is_cmp_test = 1'b0;
    case (op_code)
      dpalu_pkg::conjunction_op: alu_value = first_op & second_operand;
      dpalu_pkg::bit_clear_op: alu_value = first_op & ~second_operand;
      dpalu_pkg::disjunction_op: alu_value = first_op | second_operand;
      dpalu_pkg::exclusive_disjunction_op: alu_value = first_op ^ second_operand;
      dpalu_pkg::move_op: alu_value = second_operand;
      dpalu_pkg::move_inverted_op: alu_value = ~second_operand;
      dpalu_pkg::test_mask_op:
      begin
        alu_value = first_op & second_operand;
        is_cmp_test = 1'b1;
      end
      dpalu_pkg::test_equivalence_op:
      begin
        alu_value = first_op ^ second_operand;
        is_cmp_test = 1'b1;
      end
      dpalu_pkg::compare_op, dpalu_pkg::compare_negated_op: is_cmp_test = 1'b1;
      default: alu_value = add_bus.sum;
    endcase
  end

  // Carry and overflow depend on the operation class
  always_comb
  begin
    flag_n = alu_value[31];
    flag_z = alu_value == 32'h00000000;
    if (is_arith)
    begin
      flag_c = add_bus.cout;
      flag_v = add_bus.c31 ^ add_bus.cout;
    end
    else
    begin
      // Unshifted operand leaves carry as it was
      flag_c = shift_occurred ? shifter_carry : carry_in_flag;
      flag_v = state_reg.status[dpalu_pkg::FLAG_V_POS];
    end
  end

  // Which bits a PC destination write may touch
  always_comb
  begin
    if (!set_flags)
    begin
      write_mask = dpalu_pkg::PC_FIELD_MASK;
    end
    else if (user_mode)
    begin
      write_mask = dpalu_pkg::USER_WRITE_MASK;
    end
    else
    begin
      write_mask = dpalu_pkg::ALL_BITS_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.dest_write = 1'b0;
    state_next.shifter_operand = shifter_word;
    state_next.shift_amount = amount_word;
    if (op_valid)
    begin
      if (is_cmp_test)
      begin
        state_next.result = alu_value;
        if (status_write && user_mode)
        begin
          state_next.status = (state_reg.status & ~dpalu_pkg::CMP_USER_MASK)
                              | (alu_value & dpalu_pkg::CMP_USER_MASK);
        end
        else if (status_write)
        begin
          state_next.status = (state_reg.status & ~dpalu_pkg::CMP_PRIV_MASK)
                              | (alu_value & dpalu_pkg::CMP_PRIV_MASK);
        end
        else
        begin
          state_next.status[dpalu_pkg::FLAG_N_POS] = flag_n;
          state_next.status[dpalu_pkg::FLAG_Z_POS] = flag_z;
          state_next.status[dpalu_pkg::FLAG_C_POS] = flag_c;
          state_next.status[dpalu_pkg::FLAG_V_POS] = flag_v;
        end
      end
      else if (dest_is_pc)
      begin
        // Flags here come from the result word, not from the ALU
        state_next.result = alu_value;
        state_next.status = (state_reg.status & ~write_mask) | (alu_value & write_mask);
      end
      else
      begin
        state_next.result = alu_value;
        state_next.dest_write = 1'b1;
        if (set_flags)
        begin
          state_next.status[dpalu_pkg::FLAG_N_POS] = flag_n;
          state_next.status[dpalu_pkg::FLAG_Z_POS] = flag_z;
          state_next.status[dpalu_pkg::FLAG_C_POS] = flag_c;
          state_next.status[dpalu_pkg::FLAG_V_POS] = flag_v;
        end
      end
    end
  end

  // Single register stage for the whole state
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_reg.status <= dpalu_pkg::STATUS_RESET;
      state_reg.result <= dpalu_pkg::WORD_RESET;
      state_reg.dest_write <= 1'b0;
      state_reg.shifter_operand <= dpalu_pkg::WORD_RESET;
      state_reg.shift_amount <= dpalu_pkg::WORD_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign result_reg = state_reg.result;
  assign dest_write_reg = state_reg.dest_write;
  assign pc_status_reg = state_reg.status;
  assign shifter_operand_reg = state_reg.shifter_operand;
  assign shift_amount_reg = state_reg.shift_amount;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_add_carry_sum: assert property (
    op_valid && op_code == dpalu_pkg::add_carry_op && !dest_is_pc
    |=> result_reg == $past(first_op) + $past(second_operand)
        + {31'h00000000, $past(carry_in_flag)}
  ) else $error("add with carry result wrong");

  a_sub_carry_value: assert property (
    op_valid && op_code == dpalu_pkg::subtract_with_carry_op && !carry_in_flag
    |=> result_reg == $past(first_op) - $past(second_operand) - 32'h00000001
  ) else $error("subtract with clear carry result wrong");

  a_rev_sub_value: assert property (
    op_valid && op_code == dpalu_pkg::reverse_subtract_op
    |=> result_reg == $past(second_operand) - $past(first_op)
  ) else $error("reverse subtract result wrong");

  a_sub_carry_borrow: assert property (
    op_valid && op_code == dpalu_pkg::compare_op && !status_write
    |=> pc_status_reg[dpalu_pkg::FLAG_C_POS] == ($past(first_op) >= $past(second_operand))
  ) else $error("compare carry is not the no-borrow bit");

  a_compare_no_write: assert property (
    op_valid && (op_code == dpalu_pkg::compare_op || op_code == dpalu_pkg::test_mask_op)
    |=> !dest_write_reg
  ) else $error("compare or test wrote a destination");

  a_test_keeps_v: assert property (
    op_valid && op_code == dpalu_pkg::test_equivalence_op && !status_write
    |=> $stable(pc_status_reg[dpalu_pkg::FLAG_V_POS])
        && pc_status_reg[dpalu_pkg::FLAG_Z_POS] == ($past(first_op) == $past(second_operand))
  ) else $error("test equivalence flags wrong");

  a_pc_dest_plain: assert property (
    op_valid && !is_cmp_test && dest_is_pc && !set_flags
    |=> (pc_status_reg & ~dpalu_pkg::PC_FIELD_MASK)
        == ($past(pc_status_reg) & ~dpalu_pkg::PC_FIELD_MASK)
  ) else $error("status bits changed by plain PC write");

  a_pc_dest_user: assert property (
    op_valid && !is_cmp_test && dest_is_pc && set_flags && user_mode
    |=> pc_status_reg[27:26] == $past(pc_status_reg[27:26])
        && pc_status_reg[1:0] == $past(pc_status_reg[1:0])
        && pc_status_reg[31:28] == $past(alu_value[31:28])
  ) else $error("user mode PC write touched protected bits");
  a_first_pc_gated: assert property (
    first_is_pc |-> first_op == (pc_status_reg & dpalu_pkg::PC_FIELD_MASK)
  ) else $error("first operand is not the gated PC word");

  a_amount_pc_gated: assert property (
    amount_is_pc ##1 1'b1
    |-> shift_amount_reg == ($past(pc_status_reg) & dpalu_pkg::PC_FIELD_MASK)
  ) else $error("shift amount from PC not gated");

  a_flags_hold: assert property (
    op_valid && !is_cmp_test && !dest_is_pc && !set_flags
    |=> $stable(pc_status_reg)
  ) else $error("flags changed without update bit");

endmodule

// ===== core/dpalu_add_if.sv
// Purpose: Carries operands and results between the ALU and its adder.
// Assumes: Purely combinational use within one clock domain.
// Notes: c31 is the carry into the top bit, cout the carry out of it.
`timescale 1ns/100ps
interface dpalu_add_if;
  logic [31:0] a;
  logic [31:0] b;
  logic cin;
  logic [31:0] sum;
  logic cout;
  logic c31;
  modport adder (input a, input b, input cin, output sum, output cout, output c31);
  modport user (output a, output b, output cin, input sum, input cout, input c31);
endinterface

// ===== core/dpalu_adder.sv
// Purpose: 32-bit adder with carry in, carry out and carry into bit 31.
// Assumes: Subtraction is done by the caller inverting one operand.
// Notes: Two sums share inputs; synthesis merges them.
`timescale 1ns/100ps
module dpalu_adder (
  dpalu_add_if.adder bus
);
  logic [31:0] low_sum;
  logic [32:0] full_sum;

  // Low 31 bits alone expose the carry into the top bit
  assign low_sum = {1'b0, bus.a[30:0]} + {1'b0, bus.b[30:0]} + {31'h00000000, bus.cin};
  assign full_sum = {1'b0, bus.a} + {1'b0, bus.b} + {32'h00000000, bus.cin};
  assign bus.c31 = low_sum[31];
  assign bus.sum = full_sum[31:0];
  assign bus.cout = full_sum[32];
endmodule

// ===== core/dpalu_pkg.sv
// Purpose: Shared constants and types for the data-processing ALU.
// Assumes: 32-bit combined program-counter/status word, flags at the top.
// Notes: Reset value of the status word is a plain default.
package dpalu_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned FLAG_N_POS = 31;
  localparam int unsigned FLAG_Z_POS = 30;
  localparam int unsigned FLAG_C_POS = 29;
  localparam int unsigned FLAG_V_POS = 28;
  localparam int unsigned MASK_I_POS = 27;
  localparam int unsigned MASK_F_POS = 26;
  localparam int unsigned PC_HI_POS = 25;
  localparam int unsigned PC_LO_POS = 2;
  localparam int unsigned MODE_HI_POS = 1;
  localparam int unsigned MODE_LO_POS = 0;

  // Field masks over the combined word
  localparam logic [31:0] PC_FIELD_MASK = 32'h03FFFFFC;
  localparam logic [31:0] FLAGS_FIELD_MASK = 32'hF0000000;
  localparam logic [31:0] USER_WRITE_MASK = 32'hF3FFFFFC;
  localparam logic [31:0] CMP_USER_MASK = 32'hF0000000;
  localparam logic [31:0] CMP_PRIV_MASK = 32'hFC000003;
  localparam logic [31:0] ALL_BITS_MASK = 32'hFFFFFFFF;

  // Modes and reset values
  localparam logic [1:0] USER_MODE = 2'h0;
  localparam logic [31:0] STATUS_RESET = 32'h0C000003;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    conjunction_op,
    exclusive_disjunction_op,
    subtract_op,
    reverse_subtract_op,
    add_op,
    add_carry_op,
    subtract_with_carry_op,
    reverse_subtract_carry_op,
    test_mask_op,
    test_equivalence_op,
    compare_op,
    compare_negated_op,
    disjunction_op,
    move_op,
    bit_clear_op,
    move_inverted_op
  } dpalu_op_t;

endpackage

// ===== core/dpalu_status_gate.sv
// Purpose: Selects an operand word, substituting the combined PC/status word.
// Assumes: pc_word is the live combined word held by the ALU.
// Notes: CLEAR_STATUS picks whether status bits reach the consumer.
`timescale 1ns/100ps
module dpalu_status_gate #(
  parameter bit CLEAR_STATUS = 1'b1
) (
  input wire logic [31:0] word_in,
  input wire logic [31:0] pc_word,
  input wire logic from_pc,
  output logic [31:0] word_out
);
  // Status bits stripped or kept when the PC word is the source
  always_comb
  begin
    if (!from_pc)
    begin
      word_out = word_in;
    end
    else if (CLEAR_STATUS)
    begin
      word_out = pc_word & dpalu_pkg::PC_FIELD_MASK;
    end
    else
    begin
      word_out = pc_word;
    end
  end
endmodule

// ===== sim/dpalu_shifter_model.sv
// Purpose: Behavioural barrel shifter feeding the second operand to the ALU.
// Assumes: Left shifts only, amount 0 to 31; zero means no shift.
// Notes: Carry is the last bit shifted out; it is 0 and unused without a shift.
`timescale 1ns/100ps
module dpalu_shifter_model (
  input wire logic [31:0] shift_raw,
  input wire logic [4:0] shift_amt,
  output logic [31:0] second_operand,
  output logic shifter_carry,
  output logic shift_occurred
);
  // Shift and last bit out, settled combinationally like the real shifter
  always_comb
  begin
    second_operand = shift_raw << shift_amt;
    shift_occurred = (shift_amt != 5'h00);
    shifter_carry = shift_occurred ? shift_raw[6'h20 - {1'b0, shift_amt}] : 1'b0;
  end
endmodule

// ===== sim/tb_data_processing_alu.sv
// Purpose: Self-checking bench for the data-processing ALU.
// Assumes: One op per valid cycle, results one clock after it is taken.
// Notes: Mode sequence runs privileged first, since user mode is one-way.
`timescale 1ns/100ps
module tb_data_processing_alu;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  dpalu_pkg::dpalu_op_t op_code = dpalu_pkg::move_op;
  logic set_flags = 1'b0;
  logic status_write = 1'b0;
  logic dest_is_pc = 1'b0;
  logic [31:0] first_source_reg = 32'h00000000;
  logic first_is_pc = 1'b0;
  logic [31:0] second_operand;
  logic shifter_carry;
  logic shift_occurred;
  logic [31:0] shifter_source = 32'h00000000;
  logic shifter_source_is_pc = 1'b0;
  logic [31:0] amount_source = 32'h00000000;
  logic amount_is_pc = 1'b0;
  logic [31:0] result_reg;
  logic dest_write_reg;
  logic [31:0] pc_status_reg;
  logic [31:0] shifter_operand_reg;
  logic [31:0] shift_amount_reg;
  logic [31:0] shift_raw = 32'h00000000;
  logic [4:0] shift_amt = 5'h00;
  logic [31:0] exp_psr = dpalu_pkg::STATUS_RESET;
  int errors = 0;
  int total_checks = 0;

  always #50 clock = ~clock;

  dpalu DUT (.clock(clock), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .set_flags(set_flags), .status_write(status_write), .dest_is_pc(dest_is_pc),
    .first_source_reg(first_source_reg), .first_is_pc(first_is_pc),
    .second_operand(second_operand), .shifter_carry(shifter_carry),
    .shift_occurred(shift_occurred), .shifter_source(shifter_source),
    .shifter_source_is_pc(shifter_source_is_pc), .amount_source(amount_source),
    .amount_is_pc(amount_is_pc), .result_reg(result_reg), .dest_write_reg(dest_write_reg),
    .pc_status_reg(pc_status_reg), .shifter_operand_reg(shifter_operand_reg),
    .shift_amount_reg(shift_amount_reg));

  dpalu_shifter_model partner (.shift_raw(shift_raw), .shift_amt(shift_amt),
    .second_operand(second_operand), .shifter_carry(shifter_carry),
    .shift_occurred(shift_occurred));

  // ----------------------------------------------------------------
  // Checking and reference
  // ----------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] expect_v);
    total_checks++;
    if (seen !== expect_v)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, expect_v, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Returns {N, Z, C, V, result}; the carry in is the stored flag
  function automatic logic [35:0] model(dpalu_pkg::dpalu_op_t op, logic [31:0] a,
    logic [31:0] b, logic cin, logic sc, logic so, logic vin);
    logic [32:0] s;
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] r;
    logic k;
    logic c;
    logic v;
    logic ar;
    logic rev;
    logic sub;
    // Subtractions add the inverted subtrahend; reverse forms swap sides
    rev = op inside {dpalu_pkg::reverse_subtract_op, dpalu_pkg::reverse_subtract_carry_op};
    sub = rev || op inside {dpalu_pkg::subtract_op, dpalu_pkg::compare_op,
      dpalu_pkg::subtract_with_carry_op};
    x = rev ? b : a;
    y = !sub ? b : rev ? ~a : ~b;
    k = (op inside {dpalu_pkg::add_carry_op, dpalu_pkg::subtract_with_carry_op,
      dpalu_pkg::reverse_subtract_carry_op}) ? cin : sub;
    ar = 1'b0;
    r = 32'h00000000;
    c = so ? sc : cin;
    v = vin;
    case (op)
      dpalu_pkg::conjunction_op, dpalu_pkg::test_mask_op: r = a & b;
      dpalu_pkg::bit_clear_op: r = a & ~b;
      dpalu_pkg::disjunction_op: r = a | b;
      dpalu_pkg::exclusive_disjunction_op, dpalu_pkg::test_equivalence_op: r = a ^ b;
      dpalu_pkg::move_op: r = b;
      dpalu_pkg::move_inverted_op: r = ~b;
      default: ar = 1'b1;
    endcase
    if (ar)
    begin
      s = {1'b0, x} + {1'b0, y} + {32'h00000000, k};
      r = s[31:0];
      c = s[32];
      v = (x[31] == y[31]) && (r[31] != x[31]);
    end
    return {r[31], r == 32'h00000000, c, v, r};
  endfunction

  // Presents one op, predicts the outcome, then judges it one edge later
  task automatic run_op(dpalu_pkg::dpalu_op_t op, logic s, logic sw, logic dpc,
    logic [31:0] a);
    logic [35:0] m;
    logic [31:0] k;
    logic cmp;
    logic usr;
    op_code = op;
    set_flags = s;
    status_write = sw;
    dest_is_pc = dpc;
    first_source_reg = a;
    op_valid = 1'b1;
    #1;
    cmp = op inside {dpalu_pkg::compare_op, dpalu_pkg::compare_negated_op,
      dpalu_pkg::test_mask_op, dpalu_pkg::test_equivalence_op};
    usr = (exp_psr[1:0] == dpalu_pkg::USER_MODE);
    m = model(op, first_is_pc ? (exp_psr & dpalu_pkg::PC_FIELD_MASK) : a, second_operand,
      exp_psr[29], shifter_carry, shift_occurred, exp_psr[28]);
    k = usr ? dpalu_pkg::CMP_USER_MASK : dpalu_pkg::CMP_PRIV_MASK;
    if (!cmp && dpc)
      k = !s ? dpalu_pkg::PC_FIELD_MASK : usr ? dpalu_pkg::USER_WRITE_MASK : 32'hFFFFFFFF;
    if ((cmp && sw) || (!cmp && dpc))
      exp_psr = (exp_psr & ~k) | (m[31:0] & k);
    else if (cmp || s)
      exp_psr[31:28] = m[35:32];
    @(posedge clock);
    #1;
    // Valid stays high: back-to-back ops, one assignment per time step
    check("result", result_reg, m[31:0]);
    check("result", result_reg, m[31:0]);
    check("dest_write", {31'h0, dest_write_reg}, {31'h0, !cmp && !dpc});
    check("status", pc_status_reg, exp_psr);
    check("status", pc_status_reg, exp_psr);
  endtask

  task automatic set_shift(logic [31:0] raw, logic [4:0] amt);
    shift_raw = raw;
    shift_amt = amt;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Privileged mode: plain PC write, status-write test, full PC write into user
  task automatic t_privileged();
    set_shift(32'h12345678, 5'h00);
    run_op(dpalu_pkg::move_op, 1'b0, 1'b0, 1'b1, 32'h0);
    set_shift(32'hAC000003, 5'h00);
    run_op(dpalu_pkg::test_equivalence_op, 1'b0, 1'b1, 1'b0, 32'h0);
    set_shift(32'h50000104, 5'h00);
    run_op(dpalu_pkg::move_op, 1'b1, 1'b0, 1'b1, 32'h0);
  endtask

  // User mode: status-write compare loads flags only; PC write keeps I, F, mode
  task automatic t_user();
    set_shift(32'h20000000, 5'h00);
    run_op(dpalu_pkg::compare_negated_op, 1'b0, 1'b1, 1'b0, 32'h40000000);
    set_shift(32'h00000000, 5'h00);
    run_op(dpalu_pkg::move_inverted_op, 1'b1, 1'b0, 1'b1, 32'h0);
  endtask

  // Every op over operands that overflow, carry and shift out a one
  task automatic t_all_ops(logic s);
    logic [31:0] av[3] = '{32'h80000000, 32'h7FFFFFFF, 32'h00000005};
    logic [31:0] rv[3] = '{32'h40000000, 32'h00000001, 32'h80000005};
    logic [4:0] sv[3] = '{5'h01, 5'h00, 5'h01};
    for (int p = 0; p < 3; p++)
    begin
      set_shift(rv[p], sv[p]);
      for (int i = 0; i < 16; i++)
        run_op(dpalu_pkg::dpalu_op_t'(i), s, 1'b0, 1'b0, av[p]);
    end
  endtask

  // PC word as first operand, shifter source and shift amount
  task automatic t_pc_operands();
    logic [31:0] old;
    old = exp_psr;
    shifter_source_is_pc = 1'b1;
    amount_is_pc = 1'b1;
    first_is_pc = 1'b1;
    set_shift(32'h00000010, 5'h00);
    run_op(dpalu_pkg::add_op, 1'b1, 1'b0, 1'b0, 32'hFFFFFFFF);
    check("shift_src", shifter_operand_reg, old);
    check("shift_amt", shift_amount_reg, old & dpalu_pkg::PC_FIELD_MASK);
    op_valid = 1'b0;
    shifter_source_is_pc = 1'b0;
    amount_is_pc = 1'b0;
    first_is_pc = 1'b0;
    shifter_source = 32'hA5A5A5A5;
    amount_source = 32'hC3C3C3C3;
    @(posedge clock);
    #1;
    check("status", pc_status_reg, exp_psr);
    check("shift_src", shifter_operand_reg, 32'hA5A5A5A5);
    check("shift_amt", shift_amount_reg, 32'hC3C3C3C3);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clock);
    #1;
    reset = 1'b0;
    check("status", pc_status_reg, dpalu_pkg::STATUS_RESET);
    check("result", result_reg, 32'h00000000);
    t_all_ops(1'b1);
    t_privileged();
    t_user();
    t_all_ops(1'b1);
    t_all_ops(1'b0);
    t_pc_operands();
    stop_test();
  end

  // About 170 cycles are needed; a hang is cut off well beyond that
  initial
  begin
    #(2000 * 100);
    errors++;
    stop_test();
  end
endmodule
